// ===== inc/ccdx_pkg.sv
/*
  shared constants and types for the call / watchdog-kick / clear / decrement executor.
  assumes one instruction cycle per clock and a 14-bit instruction word from program memory.
*/
package ccdx_pkg;
  localparam int unsigned PC_W = 13;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned K_W = 11;
  localparam int unsigned BUS_AW = 10;

  // instruction word fields
  localparam int unsigned OP_HI = 13;
  localparam int unsigned OP_LO = 8;
  localparam int unsigned CALL_LO = 11;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned LATCH_HI = 4;
  localparam int unsigned LATCH_LO = 3;
  localparam logic [2:0] CALL_TOP = 3'h4;
  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_KICK = 6'h01;
  localparam logic [5:0] OP_MINUS = 6'h03;
  localparam logic [5:0] OP_ZERO_ACC = 6'h04;
  localparam logic [5:0] OP_ZERO_FILE = 6'h05;
  localparam logic [5:0] OP_INVERT = 6'h09;
  localparam logic [5:0] OP_MINUS_SKIP = 6'h0b;
  localparam logic DEST_ACC = 1'b0;

  // gray along exec -> discard -> bubble
  typedef enum logic [1:0] {
    PH_EXEC = 2'b00,
    PH_DISCARD = 2'b01,
    PH_BUBBLE = 2'b11
  } ccdx_phase_t;

  typedef struct packed {
    logic expired_flag_n;
    logic sleep_flag_n;
    logic zero;
  } ccdx_flags_t;
  localparam ccdx_flags_t FLAGS_RST = 3'h6;

  // register map, byte addresses
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_STATUS = 10'h004;
  localparam logic [9:0] REG_ACC = 10'h008;
  localparam logic [9:0] REG_LATCH = 10'h00c;
  localparam logic [9:0] REG_PC = 10'h010;
  localparam logic [9:0] REG_WDOG = 10'h014;
  localparam logic [9:0] REG_STACK = 10'h018;
  localparam int unsigned FILE_SEL_BIT = 9;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned WDOG_PRE_LSB = 8;
  localparam int unsigned STACK_SP_LSB = 16;
endpackage

// ===== logic/ccdx_core.sv
/*
  executor for subroutine call, watchdog_kick, invert_file_reg, zero_file_reg,
  zero_accumulator, minus_one_file_reg and minus_one_skip_if_null, with an avalon-mm slave.
  assumes an asynchronous program memory on the same clock: instr_word answers fetch_addr
  within the cycle.
*/
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
// What this block does
// - a call first pushes pc plus one onto the return stack head
// - a call loads its eleven-bit target into pc bits 10 to 0
// - a call loads pc bits 12 and 11 from high latch bits 4 and 3
// - a call takes two cycles and leaves every status flag unchanged
// - watchdog_kick zeroes the watchdog counter and its prescaler
// - watchdog_kick sets expired_flag_n and sleep_flag_n to one
// - destination bit 0 writes the accumulator, 1 writes the file register
// - invert_file_reg complements the register, routes result, updates zero flag
// - zero_file_reg writes 00h to the register and sets zero flag
// - zero_accumulator writes 00h to the accumulator and sets zero flag
// - minus_one_file_reg subtracts one, routes result, updates zero flag
// - minus_one_skip_if_null subtracts one, routes result, touches no flag
// - a zero skip result discards the next word, two cycles in total
// - a nonzero skip result lets the next instruction run normally
`timescale 1ns/100ps
`default_nettype none
module ccdx_core #(
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned PRESC_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [12:0] fetch_addr,
  input wire logic [13:0] instr_word
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_chk_stack
    $error("STACK_DEPTH must be a power of two, at least 2");
  end
  if (PRESC_W < 1 || PRESC_W > 8) begin : g_chk_presc
    $error("PRESC_W must be 1 to 8");
  end

  typedef struct packed {
    logic run;
    logic ack;
    logic [31:0] rdata;
    ccdx_pkg::ccdx_phase_t phase;
    ccdx_pkg::ccdx_flags_t flags;
    logic [7:0] acc;
    logic [7:0] latch;
    logic [12:0] pc;
    logic [7:0] wd_cnt;
    logic [PRESC_W-1:0] wd_pre;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [127:0][7:0] file;
  } ccdx_state_t;

  localparam ccdx_state_t STATE_RST = '{phase: ccdx_pkg::PH_EXEC, flags: ccdx_pkg::FLAGS_RST, default: '0};

  ccdx_state_t st;
  ccdx_state_t next_st;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // decoded fields of the word presented this cycle
  logic [5:0] op;
  logic [6:0] faddr;
  logic dest;
  logic is_call;
  logic ex;
  logic [7:0] fval;
  logic [7:0] res;
  logic [12:0] stack_head;
  logic [9:0] word_addr;
  logic [31:0] wmerged;

  assign op = instr_word[ccdx_pkg::OP_HI:ccdx_pkg::OP_LO];
  assign faddr = instr_word[ccdx_pkg::FADDR_W-1:0];
  assign dest = instr_word[ccdx_pkg::DEST_BIT];
  assign is_call = instr_word[ccdx_pkg::OP_HI:ccdx_pkg::CALL_LO] == ccdx_pkg::CALL_TOP;
  assign ex = st.run && st.phase == ccdx_pkg::PH_EXEC;
  assign fval = st.file[faddr];
  assign res = (op == ccdx_pkg::OP_INVERT) ? ~fval : fval - 8'h01;
  assign stack_head = st.stack[st.sp - SP_W'(1)];
  assign word_addr = {avs_address[9:2], 2'b00};

  assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
  assign avs_readdata = st.rdata;
  assign fetch_addr = st.pc;

  always_comb begin
    next_st = st;
    wmerged = '0;
    // answer on the second cycle of every access; read data is sampled in the first, write data in the second
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    next_st.rdata = '0;
    if (avs_read && !st.ack) begin
      if (avs_address[ccdx_pkg::FILE_SEL_BIT]) begin
        next_st.rdata[7:0] = st.file[avs_address[8:2]];
      end else begin
        unique case (word_addr)
          ccdx_pkg::REG_CTRL: next_st.rdata[ccdx_pkg::CTRL_RUN] = st.run;
          ccdx_pkg::REG_STATUS: next_st.rdata[2:0] = st.flags;
          ccdx_pkg::REG_ACC: next_st.rdata[7:0] = st.acc;
          ccdx_pkg::REG_LATCH: next_st.rdata[7:0] = st.latch;
          ccdx_pkg::REG_PC: next_st.rdata[12:0] = st.pc;
          ccdx_pkg::REG_WDOG: begin
            next_st.rdata[7:0] = st.wd_cnt;
            next_st.rdata[ccdx_pkg::WDOG_PRE_LSB +: PRESC_W] = st.wd_pre;
          end
          ccdx_pkg::REG_STACK: begin
            next_st.rdata[12:0] = stack_head;
            next_st.rdata[ccdx_pkg::STACK_SP_LSB +: SP_W] = st.sp;
          end
          default: next_st.rdata = '0;
        endcase
      end
    end

    if (st.run) begin
      // watchdog advances only while the core runs
      next_st.wd_pre = st.wd_pre + PRESC_W'(1);
      if (&st.wd_pre) begin
        next_st.wd_cnt = st.wd_cnt + 8'h01;
        if (&st.wd_cnt) begin
          next_st.flags.expired_flag_n = 1'b0;
        end
      end
      unique case (st.phase)
        ccdx_pkg::PH_EXEC: begin
          next_st.pc = st.pc + 13'h0001;
          if (is_call) begin
            // stack wraps when full: the oldest return address is lost
            next_st.stack[st.sp] = st.pc + 13'h0001;
            next_st.sp = st.sp + SP_W'(1);
            next_st.pc[10:0] = instr_word[ccdx_pkg::K_W-1:0];
            next_st.pc[12:11] = st.latch[ccdx_pkg::LATCH_HI:ccdx_pkg::LATCH_LO];
            next_st.phase = ccdx_pkg::PH_BUBBLE;
          end else begin
            unique case (op)
              ccdx_pkg::OP_KICK: begin
                next_st.wd_cnt = 8'h00;
                next_st.wd_pre = '0;
                next_st.flags.expired_flag_n = 1'b1;
                next_st.flags.sleep_flag_n = 1'b1;
              end
              ccdx_pkg::OP_INVERT, ccdx_pkg::OP_MINUS, ccdx_pkg::OP_MINUS_SKIP: begin
                if (dest == ccdx_pkg::DEST_ACC) begin
                  next_st.acc = res;
                end else begin
                  next_st.file[faddr] = res;
                end
                if (op == ccdx_pkg::OP_MINUS_SKIP) begin
                  if (res == 8'h00) begin
                    next_st.phase = ccdx_pkg::PH_DISCARD;
                  end
                end else begin
                  next_st.flags.zero = res == 8'h00;
                end
              end
              ccdx_pkg::OP_ZERO_FILE: begin
                next_st.file[faddr] = 8'h00;
                next_st.flags.zero = 1'b1;
              end
              ccdx_pkg::OP_ZERO_ACC: begin
                next_st.acc = 8'h00;
                next_st.flags.zero = 1'b1;
              end
              default: next_st.pc = st.pc + 13'h0001;
            endcase
          end
        end
        ccdx_pkg::PH_DISCARD: begin
          // fetched word is dropped and the slot runs as a no-op
          next_st.pc = st.pc + 13'h0001;
          next_st.phase = ccdx_pkg::PH_EXEC;
        end
        ccdx_pkg::PH_BUBBLE: next_st.phase = ccdx_pkg::PH_EXEC;
        default: next_st.phase = ccdx_pkg::PH_EXEC;
      endcase
    end

    // apart from the run bit, core state is only writable while halted, so bus and core never collide
    if (avs_write && st.ack) begin
      if (word_addr == ccdx_pkg::REG_CTRL && avs_byteenable[0]) begin
        next_st.run = avs_writedata[ccdx_pkg::CTRL_RUN];
      end else if (!st.run) begin
        if (avs_address[ccdx_pkg::FILE_SEL_BIT]) begin
          if (avs_byteenable[0]) begin
            next_st.file[avs_address[8:2]] = avs_writedata[7:0];
          end
        end else begin
          unique case (word_addr)
            ccdx_pkg::REG_STATUS: begin
              wmerged = be_merge({29'h0, st.flags}, avs_writedata, avs_byteenable);
              next_st.flags = wmerged[2:0];
            end
            ccdx_pkg::REG_ACC: begin
              wmerged = be_merge({24'h0, st.acc}, avs_writedata, avs_byteenable);
              next_st.acc = wmerged[7:0];
            end
            ccdx_pkg::REG_LATCH: begin
              wmerged = be_merge({24'h0, st.latch}, avs_writedata, avs_byteenable);
              next_st.latch = wmerged[7:0];
            end
            ccdx_pkg::REG_PC: begin
              wmerged = be_merge({19'h0, st.pc}, avs_writedata, avs_byteenable);
              next_st.pc = wmerged[12:0];
            end
            default: wmerged = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_call;
    ex && is_call;
  endsequence
  sequence s_op(logic [5:0] code);
    ex && !is_call && op == code;
  endsequence
  sequence s_skip_taken;
    s_op(ccdx_pkg::OP_MINUS_SKIP) ##0 res == 8'h00;
  endsequence

  a_call_push_ret: assert property (s_call |=> stack_head == $past(st.pc) + 13'h0001)
    else $error("call did not push pc plus one");
  a_call_low_target: assert property (s_call |=> st.pc[10:0] == $past(instr_word[10:0]))
    else $error("call target not loaded");
  a_call_high_bits: assert property (s_call |=> st.pc[12:11] == $past(st.latch[4:3]))
    else $error("call upper pc bits wrong");
  a_call_two_cycles: assert property (s_call |=> st.phase == ccdx_pkg::PH_BUBBLE && $stable(st.flags)
    ##1 fetch_addr == $past(fetch_addr) && (st.phase == ccdx_pkg::PH_EXEC || !$past(st.run)))
    else $error("call timing or flags wrong");
  a_kick_watchdog: assert property (s_op(ccdx_pkg::OP_KICK) |=> st.wd_cnt == 8'h00 && st.wd_pre == '0)
    else $error("kick did not clear watchdog");
  a_kick_flags_set: assert property (s_op(ccdx_pkg::OP_KICK) |=> st.flags.expired_flag_n && st.flags.sleep_flag_n)
    else $error("kick did not set flags");
  a_dest_route_ok: assert property ((s_op(ccdx_pkg::OP_MINUS) or s_op(ccdx_pkg::OP_INVERT)) |=>
    ($past(dest) ? st.file[$past(faddr)] == $past(res) : st.acc == $past(res)))
    else $error("result routed to wrong destination");
  a_invert_zero: assert property (s_op(ccdx_pkg::OP_INVERT) |=> st.flags.zero == ($past(fval) == 8'hff))
    else $error("invert zero flag wrong");
  a_zero_file_reg: assert property (s_op(ccdx_pkg::OP_ZERO_FILE) |=> st.file[$past(faddr)] == 8'h00 && st.flags.zero)
    else $error("zero_file_reg wrong");
  a_zero_acc_reg: assert property (s_op(ccdx_pkg::OP_ZERO_ACC) |=> st.acc == 8'h00 && st.flags.zero)
    else $error("zero_accumulator wrong");
  a_minus_zero: assert property (s_op(ccdx_pkg::OP_MINUS) |=> st.flags.zero == ($past(fval) == 8'h01))
    else $error("decrement zero flag wrong");
  a_skip_no_flags: assert property (s_op(ccdx_pkg::OP_MINUS_SKIP) |=> $stable(st.flags.zero))
    else $error("skip changed zero flag");
  a_skip_taken_nop: assert property (s_skip_taken |=> st.phase == ccdx_pkg::PH_DISCARD
    ##1 !$past(st.run) || (st.phase == ccdx_pkg::PH_EXEC && st.pc == $past(st.pc, 2) + 13'h0002))
    else $error("taken skip did not discard one word");
  a_skip_not_taken: assert property (s_op(ccdx_pkg::OP_MINUS_SKIP) ##0 res != 8'h00 |=>
    st.phase == ccdx_pkg::PH_EXEC && st.pc == $past(st.pc) + 13'h0001)
    else $error("untaken skip stalled");
  a_single_cycle_op: assert property (ex && !is_call && op != ccdx_pkg::OP_MINUS_SKIP |=>
    st.phase == ccdx_pkg::PH_EXEC && st.pc == $past(st.pc) + 13'h0001)
    else $error("single-cycle op took longer");
endmodule
`default_nettype wire

// ===== sim/ccdx_pmem.sv
/*
  program memory partner: 8192 words of 14 bits, read combinationally from fetch_addr.
  assumes the bench loads words by hierarchical assignment while the core is halted.
*/
`timescale 1ns/100ps
`default_nettype none
module ccdx_pmem (
  input wire logic [12:0] fetch_addr,
  output logic [13:0] instr_word
);
  logic [13:0] mem [0:8191];
  // unloaded words read as nop so that a stray fetch changes no state
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 14'h0000;
    end
  end
  assign instr_word = mem[fetch_addr];
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
/*
  self-checking bench for ccdx_core: avalon master task, scenario tasks, verdict.
  assumes ccdx_pmem answers fetch_addr in the same cycle and one clock is enough.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic [12:0] fetch_addr;
  wire logic [13:0] instr_word;
  int err_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [7:0] ini [1:9] = '{8'h77, 8'h5a, 8'h01, 8'h01, 8'h0f, 8'h03, 8'h80, 8'h00, 8'h05};
  logic [7:0] fin [1:9] = '{8'h00, 8'ha5, 8'h01, 8'h00, 8'h0f, 8'h02, 8'h7f, 8'h00, 8'h05};

  always #50 clock = ~clock;

  // a 2-bit prescaler lets the watchdog counter wrap within about a thousand cycles
  ccdx_core #(.STACK_DEPTH(8), .PRESC_W(2)) uut (
    .clock(clock),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .fetch_addr(fetch_addr),
    .instr_word(instr_word)
  );
  ccdx_pmem pm (
    .fetch_addr(fetch_addr),
    .instr_word(instr_word)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon access; the edge before raising keeps back-to-back calls from double driving
  task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] data);
    logic waiting;
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= data;
    avs_read <= ~wr;
    avs_write <= wr;
    // sampled mid-cycle: waitrequest is combinational on a flop that moves at the edge itself
    do begin
      @(negedge clock);
      waiting = avs_waitrequest;
      rd = avs_readdata;
      @(posedge clock);
    end while (waiting !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic [13:0] enc(input logic [5:0] op, input logic d, input logic [6:0] f);
    return {op, d, f};
  endfunction

  task automatic t_reset();
    bus(1'b0, ccdx_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'h6);
    bus(1'b0, ccdx_pkg::REG_PC, 32'h0);
    chk("pc", rd, 32'h0);
    bus(1'b0, 10'h100, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask

  // nops only: the watchdog runs out and clears expired_flag_n; acc writes are refused while running
  task automatic t_expiry();
    bus(1'b1, ccdx_pkg::REG_PC, 32'h400);
    bus(1'b1, ccdx_pkg::REG_CTRL, 32'h1);
    bus(1'b1, ccdx_pkg::REG_ACC, 32'h33);
    repeat (1100) @(posedge clock);
    bus(1'b1, ccdx_pkg::REG_CTRL, 32'h0);
    bus(1'b0, ccdx_pkg::REG_ACC, 32'h0);
    chk("acc refused", rd, 32'h0);
    bus(1'b0, ccdx_pkg::REG_STATUS, 32'h0);
    chk("status expired", rd, 32'h2);
    $display("test expiry done");
  endtask

  task automatic t_program();
    logic [6:0] fa;
    pm.mem[0] = enc(ccdx_pkg::OP_ZERO_FILE, 1'b1, 7'h01);
    pm.mem[1] = enc(ccdx_pkg::OP_INVERT, 1'b1, 7'h02);
    pm.mem[2] = enc(ccdx_pkg::OP_MINUS, 1'b0, 7'h03);
    pm.mem[3] = enc(ccdx_pkg::OP_MINUS_SKIP, 1'b1, 7'h04);
    pm.mem[4] = enc(ccdx_pkg::OP_INVERT, 1'b1, 7'h05);
    pm.mem[5] = enc(ccdx_pkg::OP_MINUS_SKIP, 1'b1, 7'h06);
    pm.mem[6] = enc(ccdx_pkg::OP_MINUS, 1'b1, 7'h07);
    pm.mem[7] = enc(ccdx_pkg::OP_ZERO_ACC, 1'b0, 7'h00);
    pm.mem[8] = enc(ccdx_pkg::OP_MINUS_SKIP, 1'b0, 7'h09);
    pm.mem[9] = {ccdx_pkg::CALL_TOP, 11'h040};
    // tail loop: kick then call back, so the watchdog counter never advances
    pm.mem[13'h1840] = enc(ccdx_pkg::OP_KICK, 1'b0, 7'h00);
    pm.mem[13'h1841] = {ccdx_pkg::CALL_TOP, 11'h040};
    bus(1'b1, ccdx_pkg::REG_LATCH, 32'h18);
    // all three status bits low, so only the kick can raise expired_flag_n and sleep_flag_n again
    bus(1'b1, ccdx_pkg::REG_STATUS, 32'h0);
    for (int f = 1; f <= 9; f++) begin
      fa = 7'(f);
      bus(1'b1, {1'b1, fa, 2'b00}, {24'h0, ini[f]});
    end
    bus(1'b1, ccdx_pkg::REG_PC, 32'h0);
    bus(1'b1, ccdx_pkg::REG_CTRL, 32'h1);
    repeat (40) @(posedge clock);
    bus(1'b1, ccdx_pkg::REG_CTRL, 32'h0);
    for (int f = 1; f <= 9; f++) begin
      fa = 7'(f);
      bus(1'b0, {1'b1, fa, 2'b00}, 32'h0);
      chk("file reg", rd, {24'h0, fin[f]});
    end
    bus(1'b0, ccdx_pkg::REG_ACC, 32'h0);
    chk("acc", rd, 32'h4);
    bus(1'b0, ccdx_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'h7);
    bus(1'b0, ccdx_pkg::REG_PC, 32'h0);
    chk("pc loop", rd & 32'h1ffe, 32'h1840);
    bus(1'b0, ccdx_pkg::REG_STACK, 32'h0);
    chk("stack head", rd & 32'h1fff, 32'h1842);
    bus(1'b0, ccdx_pkg::REG_WDOG, 32'h0);
    chk("wdog count", {24'h0, rd[7:0]}, 32'h0);
    chk("wdog prescaler", {31'h0, rd[15:8] < 8'h03}, 32'h1);
    $display("test program done");
  endtask

  initial begin
    #400000;
    $display("watchdog timeout");
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_expiry();
    t_program();
    wrap_up();
  end
endmodule
`default_nettype wire
